/* File: dv/sfms_asserts.sv */
// Port checks of the supply fault and mode sequencer
`timescale 1ns/100ps
`default_nettype none
module sfms_asserts
   import sfms_pkg::*;
#(
   parameter int TICK_CYC     = 10,
   parameter int FIRST_SVC_MS = 350,
   parameter int RST_PULSE_MS = 1
) (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       main_uv_pin,
   input wire sfms_pins_t pins
);
   logic [31:0] await_r, await_nxt, pulse_r, pulse_nxt;
   // ----------------------------------------
   // Run lengths of the await and pulse phases
   // ----------------------------------------
   always_comb begin
      await_nxt = (!pins.watchdog_flag_n && pins.rst_out_n) ? await_r + 32'h1 : 32'h0;
      pulse_nxt = (!pins.rst_out_n && pins.int_n) ? pulse_r + 32'h1 : 32'h0;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         await_r <= 32'h0;
         pulse_r <= 32'h0;
      end else begin
         await_r <= await_nxt;
         pulse_r <= pulse_nxt;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack over one cycle");
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   // The watchdog reset pulse also holds the flag low but idles the transceiver
   a_await_pins: assert property (!pins.watchdog_flag_n |->
      pins.main_rail_en && !pins.second_supply_rail && (pins.transmit_receive_state || !pins.rst_out_n))
      else $error("await pins");
   a_await_limit: assert property (await_r <= FIRST_SVC_MS * TICK_CYC + 2) else $error("await too long");
   a_pulse_len: assert property (pulse_r <= RST_PULSE_MS * TICK_CYC + 2) else $error("pulse too long");
   // Leaving the timed reset for sleep also lifts reset, but with the main rail off
   a_pulse_return: assert property ($rose(pins.rst_out_n) && pins.main_rail_en |-> !pins.watchdog_flag_n)
      else $error("no await after reset");
   a_normal_pins: assert property (pins.second_supply_rail |->
      pins.main_rail_en && pins.watchdog_flag_n && pins.rst_out_n && pins.int_n) else $error("normal pins");
   a_uv_entry: assert property ($rose(main_uv_pin) && pins.main_rail_en && pins.int_n ##1 main_uv_pin [*2]
      |=> ##[0:2] !pins.int_n && !pins.rst_out_n) else $error("uv not taken");
   a_fault_pins: assert property (!pins.int_n |->
      !pins.rst_out_n && pins.watchdog_flag_n && !pins.second_supply_rail) else $error("fault pins");
   a_sleep_hold: assert property (!pins.main_rail_en |->
      !pins.second_supply_rail ##1 $stable(pins)) else $error("sleep pins");
   c_normal: cover property ($rose(pins.second_supply_rail));
   c_fault: cover property ($fell(pins.int_n));
   c_sleep: cover property ($fell(pins.main_rail_en));
endmodule
bind sfms_top sfms_asserts #(.TICK_CYC(TICK_CYC), .FIRST_SVC_MS(FIRST_SVC_MS), .RST_PULSE_MS(RST_PULSE_MS))
   u_chk (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .main_uv_pin, .pins);
`default_nettype wire

/* File: dv/sfms_host.sv */
// Host model: Wishbone master that services the watchdog
`timescale 1ns/100ps
`default_nettype none
`include "sfms_map.svh"
module sfms_host (
   input  wire logic        mclk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output logic             cyc = 1'b0,
   output logic             stb = 1'b0,
   output logic             we = 1'b0,
   output logic [4:0]       adr = 5'h00,
   output logic [3:0]       sel = 4'h0,
   output logic [31:0]      dat = 32'h0
);
   // No answer time assumed; the bench timeout ends a hang
   task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic refresh(input int n, input int gap);
      logic [31:0] q;
      repeat (n) begin
         access(1'b1, `SFMS_OFF_TIMER_CFG, 32'hA5, q);
         repeat (gap) @(posedge mclk);
      end
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_sfms_top.sv */
// Self-checking bench of the supply fault and mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sfms_map.svh"
module tb_sfms_top
   import sfms_pkg::*;
;
   logic       mclk, rst_n, uv, loss, cyc, stb, we, ack, irq;
   logic [4:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   sfms_pins_t pins;
   int         errors = 0, checked = 0, cycles = 0, n;
   sfms_top #(.TICK_CYC(10)) dut (.mclk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .main_uv_pin(uv), .supply_loss_pin(loss), .pins, .irq);
   sfms_host host (.mclk, .ack, .rdat, .cyc, .stb, .we, .adr, .sel, .dat(wdat));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rd(input logic [4:0] a);
      host.access(1'b0, a, 32'h0, q);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      host.access(1'b1, a, d, x);
      @(negedge mclk);
   endtask
   task automatic wait_for(input int b, input logic lvl);
      n = 0;
      while (pins[b] !== lvl && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      @(negedge mclk);
   endtask
   // Pin change plus the synchroniser and state edges
   task automatic uv_set(input logic v);
      @(posedge mclk);
      uv <= v;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic do_reset();
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      check("reset pins", pins, 32'h2E);
   endtask
   task automatic t_first_wait();
      rd(5'h14);
      check("unmapped", q, 32'h0);
      wait_for(2, 1'b0);
      check("await time", n > 3400 && n < 3502, 1);
      check("flag in pulse", pins.watchdog_flag_n, 0);
      wait_for(2, 1'b1);
      check("await again", pins, 32'h2E);
      rd(`SFMS_OFF_IRQ_STAT);
      check("timeout event", q, 32'h2);
   endtask
   task automatic t_service();
      wr(`SFMS_OFF_IRQ_MASK, 32'h1);
      wr(`SFMS_OFF_TIMER_CFG, 32'h5A);
      check("normal pins", pins, 32'h3F);
      rd(`SFMS_OFF_TIMER_CFG);
      check("timer cfg", q, 32'h5A);
      check("irq on", irq, 1);
      wr(`SFMS_OFF_IRQ_MASK, 32'h0);
      check("irq masked", irq, 0);
      wr(`SFMS_OFF_IRQ_MASK, 32'h1);
      wr(`SFMS_OFF_IRQ_STAT, 32'h1);
      check("irq cleared", irq, 0);
   endtask
   task automatic t_refresh();
      host.refresh(4, 300);
      @(negedge mclk);
      check("still normal", pins, 32'h3F);
      wait_for(2, 1'b0);
      check("refresh time", n > 150 && n < 204, 1);
      wait_for(2, 1'b1);
      check("back to await", pins, 32'h2E);
   endtask
   task automatic t_uv(input logic lp, input logic lost, input logic [31:0] st);
      wr(`SFMS_OFF_CTRL, {31'h0, lp});
      @(posedge mclk);
      loss <= lost;
      uv_set(1'b1);
      check("fault pins", {pins.rst_out_n, pins.int_n, pins.watchdog_flag_n}, 32'h1);
      rd(`SFMS_OFF_STATUS);
      check("fault state", q, st);
      uv_set(1'b0);
   endtask
   initial begin
      uv = 1'b0;
      loss = 1'b0;
      rst_n = 1'b0;
      do_reset();
      t_first_wait();
      t_service();
      t_refresh();
      wr(`SFMS_OFF_TIMER_CFG, 32'h1);
      t_uv(1'b0, 1'b0, 32'h0A);
      check("stop restart", pins, 32'h2E);
      t_uv(1'b1, 1'b1, 32'h1A);
      check("loss restart", pins, 32'h2E);
      t_uv(1'b1, 1'b0, 32'h0E);
      wait_for(5, 1'b0);
      check("timed reset", n > 980 && n < 1002, 1);
      check("sleep rails", {pins.main_rail_en, pins.second_supply_rail}, 32'h0);
      rd(`SFMS_OFF_IRQ_STAT);
      check("all events", q, 32'hF);
      do_reset();
      rd(`SFMS_OFF_IRQ_STAT);
      check("events after reset", q, 32'h0);
      check("irq after reset", irq, 0);
      finish_test();
   end
endmodule
`default_nettype wire

/* File: verilog/sfms_map.svh */
// Constants of the supply fault and mode sequencer
//
// Operation
// - After power-up: await first service, main rail on, second rail off, transceiver on.
// - No timer configuration write within 350ms: pulse reset, re-enter await mode.
// - Watchdog flag output held low while awaiting first service and during retries.
// - First service: normal mode, second rail on, flag released, reset output high.
// - Missed refresh in normal mode: pulse reset, return to await mode.
// - Undervoltage with stop selected: reset mode, reset and interrupt low, flag high.
// - Stop case: when undervoltage clears, restart in await mode.
// - Undervoltage, sleep selected, supply-loss clear: stay in reset mode 100ms.
// - During that timed reset: reset and interrupt low, watchdog flag high.
// - After the 100ms: sleep mode, main and second rails off.
`ifndef SFMS_MAP_SVH
`define SFMS_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFMS_CLK_PERIOD_NS   10
`define SFMS_MS_NS           1000000
`define SFMS_FIRST_SVC_MS    350
`define SFMS_SLEEP_RST_MS    100
`define SFMS_REFRESH_MS      50
`define SFMS_RST_PULSE_MS    1
`define SFMS_MS_W            9
`define SFMS_TICK_W          20

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define SFMS_ADR_W           5
`define SFMS_OFF_TIMER_CFG   5'h00
`define SFMS_OFF_CTRL        5'h04
`define SFMS_OFF_STATUS      5'h08
`define SFMS_OFF_IRQ_STAT    5'h0C
`define SFMS_OFF_IRQ_MASK    5'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SFMS_TCFG_W          8
`define SFMS_TCFG_RST        8'h00
`define SFMS_CTRL_LP_BIT     0
`define SFMS_IRQ_W           4
`define SFMS_IRQ_SVC         0
`define SFMS_IRQ_WDTO        1
`define SFMS_IRQ_UV          2
`define SFMS_IRQ_SLEEP       3
`define SFMS_IRQ_RST         4'h0
`define SFMS_STAT_UV_BIT     3
`define SFMS_STAT_LOSS_BIT   4

`endif

/* File: verilog/sfms_pkg.sv */
// Types of the supply fault and mode sequencer
package sfms_pkg;

   // Gray codes along await -> normal -> pulse and sleep reset -> sleep; every sleep reset entry and normal -> reset mode change more than one bit
   typedef enum logic [2:0] {
      SFMS_AWAIT   = 3'h0,
      SFMS_NORMAL  = 3'h1,
      SFMS_WD_RST  = 3'h3,
      SFMS_UV_RST  = 3'h2,
      SFMS_SLP_RST = 3'h6,
      SFMS_SLEEP   = 3'h7
   } sfms_state_t;

   typedef struct packed {
      logic main_rail_en;
      logic second_supply_rail;
      logic transmit_receive_state;
      logic rst_out_n;
      logic int_n;
      logic watchdog_flag_n;
   } sfms_pins_t;

endpackage

/* File: verilog/sfms_top.sv */
// Supply fault and mode sequencer with Wishbone register slave
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sfms_map.svh"

module sfms_top
   import sfms_pkg::*;
#(
   parameter int TICK_CYC     = `SFMS_MS_NS / `SFMS_CLK_PERIOD_NS,
   parameter int FIRST_SVC_MS = `SFMS_FIRST_SVC_MS,
   parameter int SLEEP_RST_MS = `SFMS_SLEEP_RST_MS,
   parameter int REFRESH_MS   = `SFMS_REFRESH_MS,
   parameter int RST_PULSE_MS = `SFMS_RST_PULSE_MS
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [`SFMS_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   main_uv_pin,
   input  wire logic                   supply_loss_pin,
   output sfms_pins_t                  pins,
   output logic                        irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [`SFMS_MS_W-1:0] ms_lim(input int ms);
      ms_lim = `SFMS_MS_W'(ms - 1);
   endfunction

   function automatic logic hit(input logic [`SFMS_ADR_W-1:0] off);
      hit = (wb_adr_i == off);
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic uv_m_r;
   logic uv_s_r;
   logic loss_m_r;
   logic loss_s_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         uv_m_r   <= 1'b0;
         uv_s_r   <= 1'b0;
         loss_m_r <= 1'b0;
         loss_s_r <= 1'b0;
      end else begin
         uv_m_r   <= main_uv_pin;
         uv_s_r   <= uv_m_r;
         loss_m_r <= supply_loss_pin;
         loss_s_r <= loss_m_r;
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic                    ack_r;
   logic                    ack_nxt;
   logic [31:0]             rdat_r;
   logic [31:0]             rdat_nxt;
   logic [`SFMS_TCFG_W-1:0] tcfg_r;
   logic [`SFMS_TCFG_W-1:0] tcfg_nxt;
   logic                    lp_sleep_r;
   logic                    lp_sleep_nxt;
   logic [`SFMS_IRQ_W-1:0]  istat_r;
   logic [`SFMS_IRQ_W-1:0]  istat_nxt;
   logic [`SFMS_IRQ_W-1:0]  imask_r;
   logic [`SFMS_IRQ_W-1:0]  imask_nxt;
   logic [`SFMS_IRQ_W-1:0]  ievt;
   logic                    wr_take;
   logic                    svc_wr;
   sfms_state_t             state_r;

   // A write lands on the edge where the master sees ack
   assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
   assign svc_wr  = wr_take & hit(`SFMS_OFF_TIMER_CFG) & wb_sel_i[0];

   always_comb begin
      ack_nxt      = wb_cyc_i & wb_stb_i & ~ack_r;
      rdat_nxt     = rdat_r;
      tcfg_nxt     = tcfg_r;
      lp_sleep_nxt = lp_sleep_r;
      imask_nxt    = imask_r;
      istat_nxt    = istat_r;
      if (ack_nxt) begin
         rdat_nxt = 32'h0;
         case (wb_adr_i)
            `SFMS_OFF_TIMER_CFG: begin
               rdat_nxt[`SFMS_TCFG_W-1:0] = tcfg_r;
            end
            `SFMS_OFF_CTRL: begin
               rdat_nxt[`SFMS_CTRL_LP_BIT] = lp_sleep_r;
            end
            `SFMS_OFF_STATUS: begin
               rdat_nxt[2:0]                 = state_r;
               rdat_nxt[`SFMS_STAT_UV_BIT]   = uv_s_r;
               rdat_nxt[`SFMS_STAT_LOSS_BIT] = loss_s_r;
            end
            `SFMS_OFF_IRQ_STAT: begin
               rdat_nxt[`SFMS_IRQ_W-1:0] = istat_r;
            end
            `SFMS_OFF_IRQ_MASK: begin
               rdat_nxt[`SFMS_IRQ_W-1:0] = imask_r;
            end
            default: begin
               rdat_nxt = 32'h0;
            end
         endcase
      end
      if (wr_take && wb_sel_i[0]) begin
         case (wb_adr_i)
            `SFMS_OFF_TIMER_CFG: begin
               tcfg_nxt = wb_dat_i[`SFMS_TCFG_W-1:0];
            end
            `SFMS_OFF_CTRL: begin
               lp_sleep_nxt = wb_dat_i[`SFMS_CTRL_LP_BIT];
            end
            `SFMS_OFF_IRQ_STAT: begin
               istat_nxt = istat_r & ~wb_dat_i[`SFMS_IRQ_W-1:0];
            end
            `SFMS_OFF_IRQ_MASK: begin
               imask_nxt = wb_dat_i[`SFMS_IRQ_W-1:0];
            end
            default: begin
               istat_nxt = istat_nxt;
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      istat_nxt = istat_nxt | ievt;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r      <= 1'b0;
         rdat_r     <= 32'h0;
         tcfg_r     <= `SFMS_TCFG_RST;
         lp_sleep_r <= 1'b0;
         istat_r    <= `SFMS_IRQ_RST;
         imask_r    <= `SFMS_IRQ_RST;
      end else begin
         ack_r      <= ack_nxt;
         rdat_r     <= rdat_nxt;
         tcfg_r     <= tcfg_nxt;
         lp_sleep_r <= lp_sleep_nxt;
         istat_r    <= istat_nxt;
         imask_r    <= imask_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign irq      = |(istat_r & imask_r);

   // ----------------------------------------
   // Millisecond timebase
   // ----------------------------------------
   // Restarted on each state change or service, so every
   // interval lasts whole milliseconds, never a fraction less.
   logic [`SFMS_TICK_W-1:0] tick_r;
   logic [`SFMS_TICK_W-1:0] tick_nxt;
   logic [`SFMS_MS_W-1:0]   ms_r;
   logic [`SFMS_MS_W-1:0]   ms_nxt;
   logic                    ms_tick;
   logic                    restart;
   sfms_state_t             state_nxt;

   assign ms_tick = (tick_r == `SFMS_TICK_W'(TICK_CYC - 1));
   assign restart = (state_nxt != state_r) | svc_wr;

   always_comb begin
      tick_nxt = ms_tick ? '0 : tick_r + 1'b1;
      ms_nxt   = ms_tick ? ms_r + 1'b1 : ms_r;
      if (restart) begin
         tick_nxt = '0;
         ms_nxt   = '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r <= '0;
         ms_r   <= '0;
      end else begin
         tick_r <= tick_nxt;
         ms_r   <= ms_nxt;
      end
   end

   // ----------------------------------------
   // Mode sequencer
   // ----------------------------------------
   logic uv_fault;
   logic to_sleep;

   assign uv_fault = uv_s_r;
   assign to_sleep = lp_sleep_r & ~loss_s_r;

   always_comb begin
      state_nxt = state_r;
      ievt      = `SFMS_IRQ_RST;
      case (state_r)
         SFMS_AWAIT: begin
            if (uv_fault) begin
               state_nxt = to_sleep ? SFMS_SLP_RST : SFMS_UV_RST;
            end else if (svc_wr) begin
               state_nxt = SFMS_NORMAL;
            end else if (ms_tick && ms_r == ms_lim(FIRST_SVC_MS)) begin
               state_nxt = SFMS_WD_RST;
            end
         end
         SFMS_NORMAL: begin
            if (uv_fault) begin
               state_nxt = to_sleep ? SFMS_SLP_RST : SFMS_UV_RST;
            end else if (!svc_wr && ms_tick && ms_r == ms_lim(REFRESH_MS)) begin
               state_nxt = SFMS_WD_RST;
            end
         end
         SFMS_WD_RST: begin
            if (uv_fault) begin
               state_nxt = to_sleep ? SFMS_SLP_RST : SFMS_UV_RST;
            end else if (ms_tick && ms_r == ms_lim(RST_PULSE_MS)) begin
               state_nxt = SFMS_AWAIT;
            end
         end
         SFMS_UV_RST: begin
            if (!uv_fault) begin
               state_nxt = SFMS_AWAIT;
            end
         end
         SFMS_SLP_RST: begin
            if (ms_tick && ms_r == ms_lim(SLEEP_RST_MS)) begin
               state_nxt = SFMS_SLEEP;
            end
         end
         SFMS_SLEEP: begin
            state_nxt = SFMS_SLEEP;
         end
         default: begin
            state_nxt = SFMS_AWAIT;
         end
      endcase
      if (state_r == SFMS_AWAIT && state_nxt == SFMS_NORMAL) begin
         ievt[`SFMS_IRQ_SVC] = 1'b1;
      end
      if (state_nxt == SFMS_WD_RST && state_r != SFMS_WD_RST) begin
         ievt[`SFMS_IRQ_WDTO] = 1'b1;
      end
      if ((state_nxt == SFMS_UV_RST || state_nxt == SFMS_SLP_RST) &&
          state_r != SFMS_UV_RST && state_r != SFMS_SLP_RST) begin
         ievt[`SFMS_IRQ_UV] = 1'b1;
      end
      if (state_nxt == SFMS_SLEEP && state_r != SFMS_SLEEP) begin
         ievt[`SFMS_IRQ_SLEEP] = 1'b1;
      end
   end

   // ----------------------------------------
   // Pin drive, registered from the next state
   // ----------------------------------------
   sfms_pins_t pins_r;
   sfms_pins_t pins_nxt;

   always_comb begin
      pins_nxt.main_rail_en           = 1'b1;
      pins_nxt.second_supply_rail     = 1'b0;
      pins_nxt.transmit_receive_state = 1'b0;
      pins_nxt.rst_out_n              = 1'b1;
      pins_nxt.int_n                  = 1'b1;
      pins_nxt.watchdog_flag_n        = 1'b1;
      case (state_nxt)
         SFMS_AWAIT: begin
            pins_nxt.transmit_receive_state = 1'b1;
            pins_nxt.watchdog_flag_n        = 1'b0;
         end
         SFMS_NORMAL: begin
            pins_nxt.second_supply_rail     = 1'b1;
            pins_nxt.transmit_receive_state = 1'b1;
         end
         SFMS_WD_RST: begin
            pins_nxt.rst_out_n       = 1'b0;
            pins_nxt.watchdog_flag_n = 1'b0;
         end
         SFMS_UV_RST, SFMS_SLP_RST: begin
            pins_nxt.rst_out_n = 1'b0;
            pins_nxt.int_n     = 1'b0;
         end
         SFMS_SLEEP: begin
            pins_nxt.main_rail_en = 1'b0;
         end
         default: begin
            pins_nxt.rst_out_n = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r                       <= SFMS_AWAIT;
         pins_r.main_rail_en           <= 1'b1;
         pins_r.second_supply_rail     <= 1'b0;
         pins_r.transmit_receive_state <= 1'b1;
         pins_r.rst_out_n              <= 1'b1;
         pins_r.int_n                  <= 1'b1;
         pins_r.watchdog_flag_n        <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pins_r  <= pins_nxt;
      end
   end

   assign pins = pins_r;

endmodule

`default_nettype wire
